// >>> src/alu_pkg.sv
// Constants and types of the saturating DSP datapath slice with its status flags
// ==========================================================================
// Behaviour
// - Negative flag bit 31 follows result sign
// - Zero flag bit 30 set on zero result
// - Carry bit 29: add carry, subtract no-borrow
// - Overflow flag bit 28 set on signed overflow
// - Saturation flag bit 27 is sticky
// - Saturation flag cleared only by explicit write
// - Greater-equal flags bits 19:16 readable, writable
// - Double-add: first plus doubled second operand
// - Double-sub: first minus doubled second operand
// - Both steps saturate to signed 32-bit range
// - Saturation in either step sets flag
// - Write and flags only when condition passes
package alu_pkg;

  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Flag positions in program_status_flags
  localparam int unsigned FLAG_N_BIT = 31;
  localparam int unsigned FLAG_Z_BIT = 30;
  localparam int unsigned FLAG_C_BIT = 29;
  localparam int unsigned FLAG_V_BIT = 28;
  localparam int unsigned FLAG_Q_BIT = 27;
  localparam int unsigned GE_HI_BIT = 19;
  localparam int unsigned GE_LO_BIT = 16;

  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  // Writable bits; all others read as zero
  localparam logic [31:0] FLAGS_WR_MASK = 32'hf80f_0000;

  // ==========================================================================
  // Saturation limits
  localparam logic [31:0] SAT_MAX = 32'h7fff_ffff;
  localparam logic [31:0] SAT_MIN = 32'h8000_0000;

  typedef enum logic [2:0] {
    OP_ADDS,
    OP_SUBS,
    OP_SAT_DOUBLE_ADD,
    OP_SAT_DOUBLE_SUB,
    OP_FLAGS_WRITE
  } alu_op_t;

endpackage : alu_pkg

// >>> src/sat_if.sv
// Operand and result bundle between the datapath and its saturating unit
`timescale 1ns/1ps
`default_nettype none
interface sat_if;
  logic [31:0] a;
  logic [31:0] b;
  logic sub;
  logic [31:0] res;
  logic sat;
  modport calc (input a, input b, input sub, output res, output sat);
  modport user (output a, output b, output sub, input res, input sat);
endinterface : sat_if
`default_nettype wire

// >>> src/sat_double_addsub.sv
// Saturating double-then-add/subtract unit
`timescale 1ns/1ps
`default_nettype none
module sat_double_addsub (
  sat_if.calc s
);
  import alu_pkg::*;

  logic dbl_sat;
  logic add_sat;
  logic [31:0] dbl;
  logic [32:0] sum;

  always_comb begin
    // Doubling saturates when the top two bits differ
    dbl_sat = s.b[31] ^ s.b[30];
    dbl = dbl_sat ? (s.b[31] ? SAT_MIN : SAT_MAX) : {s.b[30:0], 1'b0};
    // The saturated doubled value feeds the second step
    if (s.sub) begin
      sum = {s.a[31], s.a} - {dbl[31], dbl};
    end else begin
      sum = {s.a[31], s.a} + {dbl[31], dbl};
    end
    add_sat = sum[32] ^ sum[31];
    s.res = add_sat ? (sum[32] ? SAT_MIN : SAT_MAX) : sum[31:0];
    s.sat = dbl_sat | add_sat;
  end

endmodule : sat_double_addsub
`default_nettype wire

// >>> src/saturating_dsp_alu_flags.sv
// Datapath slice: flag-setting add/sub, saturating double ops, status flags
`timescale 1ns/1ps
`default_nettype none
module saturating_dsp_alu_flags (
  input wire logic clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire alu_pkg::alu_op_t op_sel,
  input wire logic cond_pass,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic [31:0] flags_wdata,
  output logic [31:0] result,
  output logic result_valid,
  output logic [31:0] program_status_flags
);
  import alu_pkg::*;

  typedef struct packed {
    logic [31:0] result;
    logic valid;
    logic [31:0] flags;
  } state_t;

  localparam state_t STATE_RESET = '{result: 32'h0000_0000, valid: 1'b0, flags: FLAGS_RESET};

  state_t state_q;
  state_t state_d;
  logic [32:0] add_w;
  logic [32:0] sub_w;
  logic take;

  sat_if sif ();

  sat_double_addsub u_sat (
    .s(sif.calc)
  );

  assign sif.a = first_operand;
  assign sif.b = second_operand;
  assign sif.sub = (op_sel == OP_SAT_DOUBLE_SUB);
  assign take = op_valid && cond_pass;

  // ==========================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    state_d.valid = 1'b0;
    add_w = {1'b0, first_operand} + {1'b0, second_operand};
    sub_w = {1'b0, first_operand} - {1'b0, second_operand};
    if (take) begin
      case (op_sel)
        OP_ADDS: begin
          state_d.result = add_w[31:0];
          state_d.valid = 1'b1;
          state_d.flags[FLAG_N_BIT] = add_w[31];
          state_d.flags[FLAG_Z_BIT] = (add_w[31:0] == 32'h0000_0000);
          state_d.flags[FLAG_C_BIT] = add_w[32];
          state_d.flags[FLAG_V_BIT] = (first_operand[31] == second_operand[31])
                                      && (add_w[31] != first_operand[31]);
        end
        OP_SUBS: begin
          state_d.result = sub_w[31:0];
          state_d.valid = 1'b1;
          state_d.flags[FLAG_N_BIT] = sub_w[31];
          state_d.flags[FLAG_Z_BIT] = (sub_w[31:0] == 32'h0000_0000);
          state_d.flags[FLAG_C_BIT] = ~sub_w[32];
          state_d.flags[FLAG_V_BIT] = (first_operand[31] != second_operand[31])
                                      && (sub_w[31] != first_operand[31]);
        end
        OP_SAT_DOUBLE_ADD, OP_SAT_DOUBLE_SUB: begin
          state_d.result = sif.res;
          state_d.valid = 1'b1;
          // Only the sticky bit may change here
          if (sif.sat) begin
            state_d.flags[FLAG_Q_BIT] = 1'b1;
          end
        end
        OP_FLAGS_WRITE: begin
          // Only an explicit write can clear the sticky bit
          state_d.flags = flags_wdata & FLAGS_WR_MASK;
        end
        default: begin
          state_d.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign result = state_q.result;
  assign result_valid = state_q.valid;
  assign program_status_flags = state_q.flags;

  // ==========================================================================
  // Checks
  logic is_dbl;
  logic [31:0] exp_dbl_add;
  logic [31:0] exp_dbl_sub;
  assign is_dbl = take && (op_sel == OP_SAT_DOUBLE_ADD || op_sel == OP_SAT_DOUBLE_SUB);
  assign exp_dbl_add = first_operand + {second_operand[30:0], 1'b0};
  assign exp_dbl_sub = first_operand - {second_operand[30:0], 1'b0};

  property p_n_z_adds;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_ADDS |=> program_status_flags[FLAG_N_BIT] == result[31]
      && program_status_flags[FLAG_Z_BIT] == (result == 32'h0000_0000);
  endproperty
  a_n_z_adds: assert property (p_n_z_adds) else $error("N/Z wrong after add");

  property p_z_subs;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_SUBS && first_operand == second_operand
      |=> program_status_flags[FLAG_Z_BIT] && program_status_flags[FLAG_C_BIT];
  endproperty
  a_z_subs: assert property (p_z_subs) else $error("Z/C wrong on equal subtract");

  property p_c_adds;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_ADDS |=> program_status_flags[FLAG_C_BIT] == (result < $past(first_operand));
  endproperty
  a_c_adds: assert property (p_c_adds) else $error("carry wrong after add");

  property p_v_subs;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_SUBS && first_operand == SAT_MIN && second_operand == 32'h0000_0001
      |=> program_status_flags[FLAG_V_BIT] && result == SAT_MAX;
  endproperty
  a_v_subs: assert property (p_v_subs) else $error("overflow missed on subtract");

  property p_q_sticky;
    @(posedge clk) disable iff (!resetn)
    program_status_flags[FLAG_Q_BIT] && !(take && op_sel == OP_FLAGS_WRITE)
      |=> program_status_flags[FLAG_Q_BIT];
  endproperty
  a_q_sticky: assert property (p_q_sticky) else $error("sticky flag lost");

  property p_q_clear_write;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_FLAGS_WRITE
      |=> program_status_flags == ($past(flags_wdata) & FLAGS_WR_MASK);
  endproperty
  a_q_clear_write: assert property (p_q_clear_write) else $error("flag write wrong");

  property p_ge_write;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_FLAGS_WRITE ##1 !op_valid [*2]
      |-> program_status_flags[GE_HI_BIT:GE_LO_BIT] == $past(flags_wdata[GE_HI_BIT:GE_LO_BIT], 2);
  endproperty
  a_ge_write: assert property (p_ge_write) else $error("GE flags not held");

  property p_dbl_add_exact;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_SAT_DOUBLE_ADD && second_operand[31:29] == 3'h0
      && first_operand[31:30] == 2'h0 |=> result == $past(exp_dbl_add) && result_valid;
  endproperty
  a_dbl_add_exact: assert property (p_dbl_add_exact) else $error("double-add wrong");

  property p_dbl_sub_exact;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_SAT_DOUBLE_SUB && second_operand[31:29] == 3'h0
      && first_operand[31:30] == 2'h0 |=> result == $past(exp_dbl_sub);
  endproperty
  a_dbl_sub_exact: assert property (p_dbl_sub_exact) else $error("double-sub wrong");

  property p_sat_limits;
    @(posedge clk) disable iff (!resetn)
    is_dbl && sif.sat |=> (result == SAT_MAX || result == SAT_MIN
      || $past(second_operand[31] ^ second_operand[30]))
      && program_status_flags[FLAG_Q_BIT];
  endproperty
  a_sat_limits: assert property (p_sat_limits) else $error("saturation wrong");

  property p_dbl_then_add;
    @(posedge clk) disable iff (!resetn)
    take && op_sel == OP_SAT_DOUBLE_ADD && second_operand == SAT_MIN && first_operand == SAT_MAX
      |=> result == 32'hffff_ffff && program_status_flags[FLAG_Q_BIT];
  endproperty
  a_dbl_then_add: assert property (p_dbl_then_add) else $error("wide intermediate used");

  property p_cond_fail;
    @(posedge clk) disable iff (!resetn)
    op_valid && !cond_pass |=> !result_valid && $stable(program_status_flags) && $stable(result);
  endproperty
  a_cond_fail: assert property (p_cond_fail) else $error("failed condition had effect");

  property p_dbl_keeps_flags;
    @(posedge clk) disable iff (!resetn)
    is_dbl |=> program_status_flags[31:28] == $past(program_status_flags[31:28])
      && program_status_flags[GE_HI_BIT:GE_LO_BIT]
         == $past(program_status_flags[GE_HI_BIT:GE_LO_BIT]);
  endproperty
  a_dbl_keeps_flags: assert property (p_dbl_keeps_flags) else $error("double op moved flags");

  property p_cov_dbl_sat;
    @(posedge clk) disable iff (!resetn) is_dbl && sif.sat;
  endproperty
  c_dbl_sat: cover property (p_cov_dbl_sat);

  property p_cov_q_clear;
    @(posedge clk) disable iff (!resetn)
    program_status_flags[FLAG_Q_BIT] ##1 !program_status_flags[FLAG_Q_BIT];
  endproperty
  c_q_clear: cover property (p_cov_q_clear);

  property p_cov_sub_dbl;
    @(posedge clk) disable iff (!resetn) take && op_sel == OP_SAT_DOUBLE_SUB && !sif.sat;
  endproperty
  c_sub_dbl: cover property (p_cov_sub_dbl);

  property p_cov_adds_v;
    @(posedge clk) disable iff (!resetn) take && op_sel == OP_ADDS ##1 program_status_flags[FLAG_V_BIT];
  endproperty
  c_adds_v: cover property (p_cov_adds_v);

endmodule : saturating_dsp_alu_flags
`default_nettype wire

// >>> test/reg_file_model.sv
// Register-file side model that captures written-back results
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] result,
  input wire logic result_valid,
  output logic [31:0] wb_value
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_value <= 32'h0000_0000;
    end else if (result_valid) begin
      wb_value <= result;
    end
  end
endmodule : reg_file_model
`default_nettype wire

// >>> test/saturating_dsp_alu_flags_tb_top.sv
// Self-checking bench of the saturating datapath slice and its status flags
`timescale 1ns/1ps
`default_nettype none
module saturating_dsp_alu_flags_tb_top;
  import alu_pkg::*;
  logic clk, resetn, op_valid, cond_pass, result_valid;
  alu_op_t op_sel;
  logic [31:0] first_operand, second_operand, flags_wdata, result, program_status_flags;
  logic [31:0] wb_value, exp_flags, exp_result;
  bit sat_hit;
  int bad_count, total_checks;

  saturating_dsp_alu_flags DUT (.clk(clk), .resetn(resetn), .op_valid(op_valid),
    .op_sel(op_sel), .cond_pass(cond_pass), .first_operand(first_operand),
    .second_operand(second_operand), .flags_wdata(flags_wdata), .result(result),
    .result_valid(result_valid), .program_status_flags(program_status_flags));
  reg_file_model partner (.clk(clk), .resetn(resetn), .result(result),
    .result_valid(result_valid), .wb_value(wb_value));

  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Clamp a wide signed value into the 32-bit signed range
  function automatic logic [31:0] sat34(input logic signed [33:0] x);
    if (x > 34'sh0_7fff_ffff) begin
      sat_hit = 1'b1;
      return SAT_MAX;
    end
    if (x < -34'sh0_8000_0000) begin
      sat_hit = 1'b1;
      return SAT_MIN;
    end
    return x[31:0];
  endfunction : sat34

  // One operation: predict, drive for one cycle, compare, then check write-back
  task automatic run(input alu_op_t op, input logic cp, input logic [31:0] a,
                     input logic [31:0] b, input logic [31:0] w);
    logic [32:0] s;
    logic [31:0] d, r;
    logic v;
    v = 1'b0;
    r = exp_result;
    sat_hit = 1'b0;
    if (cp) begin
      case (op)
        OP_ADDS, OP_SUBS: begin
          s = {1'b0, a} + ((op == OP_ADDS) ? {1'b0, b} : {1'b0, ~b} + 33'h1);
          exp_flags[31:28] = {s[31], s[31:0] == 32'h0, s[32],
            ((a[31] == b[31]) == (op == OP_ADDS)) && (s[31] != a[31])};
          r = s[31:0];
          v = 1'b1;
        end
        OP_SAT_DOUBLE_ADD, OP_SAT_DOUBLE_SUB: begin
          d = sat34({b[31], b, 1'b0});
          r = sat34((op == OP_SAT_DOUBLE_ADD) ? {a[31], a[31], a} + {d[31], d[31], d}
                                              : {a[31], a[31], a} - {d[31], d[31], d});
          if (sat_hit) exp_flags[FLAG_Q_BIT] = 1'b1;
          v = 1'b1;
        end
        OP_FLAGS_WRITE: exp_flags = w & FLAGS_WR_MASK;
        default: ;
      endcase
    end
    @(posedge clk);
    op_valid <= 1'b1;
    op_sel <= op;
    cond_pass <= cp;
    first_operand <= a;
    second_operand <= b;
    flags_wdata <= w;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    check("result_valid", {31'h0, result_valid}, {31'h0, v});
    check("flags", program_status_flags, exp_flags);
    if (v) exp_result = r;
    check("result", result, exp_result);
    @(posedge clk);
    #1;
    check("result_valid drop", {31'h0, result_valid}, 32'h0);
    check("write-back", wb_value, exp_result);
  endtask : run

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    op_valid = 1'b0;
    op_sel = OP_ADDS;
    cond_pass = 1'b0;
    first_operand = 32'h0;
    second_operand = 32'h0;
    flags_wdata = 32'h0;
    exp_flags = FLAGS_RESET;
    exp_result = 32'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check("reset flags", program_status_flags, FLAGS_RESET);
    run(OP_FLAGS_WRITE, 1'b1, 32'h0, 32'h0, 32'hffff_ffff);
    run(OP_FLAGS_WRITE, 1'b1, 32'h0, 32'h0, 32'h0000_0000);
    run(OP_FLAGS_WRITE, 1'b1, 32'h0, 32'h0, 32'h500a_0000);
    run(OP_SAT_DOUBLE_ADD, 1'b1, 32'h0000_0005, 32'h0000_0003, 32'h0);
    run(OP_SAT_DOUBLE_ADD, 1'b1, 32'hffff_ffff, 32'h4000_0000, 32'h0);
    run(OP_FLAGS_WRITE, 1'b1, 32'h0, 32'h0, 32'ha005_0000);
    run(OP_SAT_DOUBLE_SUB, 1'b1, 32'h8000_0000, 32'h0000_0001, 32'h0);
    run(OP_FLAGS_WRITE, 1'b1, 32'h0, 32'h0, 32'h0);
    run(OP_SAT_DOUBLE_SUB, 1'b1, 32'h0000_0000, 32'hc000_0000, 32'h0);
    run(OP_SAT_DOUBLE_ADD, 1'b1, 32'h0000_0001, 32'h0000_0001, 32'h0);
    run(OP_ADDS, 1'b1, 32'hffff_ffff, 32'h0000_0001, 32'h0);
    run(OP_ADDS, 1'b1, 32'h7fff_ffff, 32'h0000_0001, 32'h0);
    run(OP_SUBS, 1'b1, 32'h0000_0001, 32'h0000_0002, 32'h0);
    run(OP_SUBS, 1'b1, 32'h0000_0002, 32'h0000_0001, 32'h0);
    run(OP_SUBS, 1'b1, 32'h8000_0000, 32'h0000_0001, 32'h0);
    run(OP_SUBS, 1'b1, 32'h0000_0005, 32'h0000_0005, 32'h0);
    run(OP_SAT_DOUBLE_SUB, 1'b1, 32'h0000_0010, 32'h0000_0003, 32'h0);
    // Reset in mid-run with the sticky flag set
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    exp_flags = FLAGS_RESET;
    exp_result = 32'h0000_0000;
    check("mid reset flags", program_status_flags, exp_flags);
    check("mid reset result", result, exp_result);
    check("mid reset valid", {31'h0, result_valid}, 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    run(OP_SAT_DOUBLE_ADD, 1'b1, 32'h7fff_ffff, 32'h8000_0000, 32'h0);
    run(OP_FLAGS_WRITE, 1'b1, 32'h0, 32'h0, 32'h0);
    run(OP_SAT_DOUBLE_ADD, 1'b1, 32'h7fff_ffff, 32'h0000_0001, 32'h0);
    run(OP_SAT_DOUBLE_ADD, 1'b0, 32'h7fff_ffff, 32'h7fff_ffff, 32'h0);
    run(OP_FLAGS_WRITE, 1'b0, 32'h0, 32'h0, 32'h0);
    run(alu_op_t'(3'h7), 1'b1, 32'h1234_5678, 32'h0000_0001, 32'h0);
    tally_and_finish();
  end
endmodule : saturating_dsp_alu_flags_tb_top
`default_nettype wire
